// ===== design/pct_counter.sv
// Prescaled 8-bit count with run, clear and periodic cause pulses.
`timescale 1ns/1ps
`include "pct_consts.svh"
module pct_counter
  import pct_pkg::*;
#(
  parameter int TICK_CYCLES = `PCT_CLK_HZ / `PCT_TICK_HZ
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control.
  input wire logic run_in,
  input wire logic clear_in,
  // State and causes.
  output pct_byte_t count_out,
  output pct_irq_t cause_out
);
  // --------------------------------------------------------------------
  // Prescaler and counter.
  // --------------------------------------------------------------------
  pct_pre_t pre_reg;
  pct_pre_t pre_next;
  pct_byte_t count_reg;
  pct_byte_t count_next;
  wire tick = run_in && (pre_reg == `PCT_PRE_W'(TICK_CYCLES - 1));
  wire [7:0] count_inc = count_reg + 8'h01;
  wire [3:0] tap_old = {count_reg[`PCT_TAP_32HZ], count_reg[`PCT_TAP_8HZ],
                        count_reg[`PCT_TAP_2HZ], count_reg[`PCT_TAP_1HZ]};
  wire [3:0] tap_new = {count_inc[`PCT_TAP_32HZ], count_inc[`PCT_TAP_8HZ],
                        count_inc[`PCT_TAP_2HZ], count_inc[`PCT_TAP_1HZ]};

  // Clear restarts the prescaler too, so the first step after it is whole.
  assign pre_next = (clear_in || tick) ? `PCT_PRE_ZERO :
                    run_in ? pre_reg + `PCT_PRE_ONE : pre_reg;
  assign count_next = clear_in ? `PCT_RST_BYTE :
                      tick ? count_inc : count_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pre_reg <= `PCT_PRE_ZERO;
      count_reg <= `PCT_RST_BYTE;
    end else begin
      pre_reg <= pre_next;
      count_reg <= count_next;
    end
  end

  // --------------------------------------------------------------------
  // Cause pulses on the falling edge of each tap bit.
  // --------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `PCT_IRQ_W; i = i + 1) begin : g_cause
      assign cause_out[i] = tick && !clear_in && tap_old[i] && !tap_new[i];
    end
  endgenerate

  assign count_out = count_reg;
endmodule : pct_counter

// ===== design/pct_top.sv
// Periodic clock timer with AHB-Lite register slave and interrupt.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "pct_consts.svh"
module pct_top
  import pct_pkg::*;
#(
  parameter int TICK_CYCLES = `PCT_CLK_HZ / `PCT_TICK_HZ
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_b_in,
  // AHB-Lite slave.
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Interrupt.
  output logic irq_out
);
  // --------------------------------------------------------------------
  // Address phase capture.
  // --------------------------------------------------------------------
  logic wr_pend_reg;
  logic [29:0] wr_idx_reg;
  logic run_reg;
  logic run_next;
  pct_irq_t en_reg;
  pct_irq_t en_next;
  pct_irq_t flag_reg;
  pct_irq_t flag_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  pct_byte_t count_value;
  pct_irq_t cause;

  // The size is not checked; only whole-word transfers are expected.
  wire addr_valid = hsel_in && hready_in && htrans_in[`PCT_HTRANS_NONSEQ_BIT];
  wire addr_wr = addr_valid && hwrite_in;
  wire addr_rd = addr_valid && !hwrite_in;
  wire [29:0] addr_idx = haddr_in[31:2];
  wire unused_ok = &{1'b0, hsize_in, haddr_in[1:0]};

  // --------------------------------------------------------------------
  // Data phase write decode.
  // --------------------------------------------------------------------
  wire wr_ctl = wr_pend_reg && (wr_idx_reg == `PCT_IDX_CONTROL);
  wire wr_en = wr_pend_reg && (wr_idx_reg == `PCT_IDX_ENABLE);
  wire wr_flag = wr_pend_reg && (wr_idx_reg == `PCT_IDX_FLAGS);
  wire count_clear = wr_ctl && hwdata_in[`PCT_BIT_CLEAR];
  // A read right behind a clear must not show the stale count.
  wire [7:0] count_shown = count_clear ? `PCT_RST_BYTE : count_value;
  wire [3:0] flag_w1c = wr_flag ? hwdata_in[`PCT_IRQ_W-1:0] : `PCT_RST_IRQ;

  assign run_next = wr_ctl ? hwdata_in[`PCT_BIT_RUN] : run_reg;
  assign en_next = wr_en ? hwdata_in[`PCT_IRQ_W-1:0] : en_reg;
  // A cause in the cycle of its clear keeps the flag set.
  assign flag_next = (flag_reg & ~flag_w1c) | cause;

  // --------------------------------------------------------------------
  // Read data, built from next values (the count from count_shown, not count_next) so a write just before is seen.
  // --------------------------------------------------------------------
  wire rd_ctl = addr_rd && (addr_idx == `PCT_IDX_CONTROL);
  wire rd_cnt = addr_rd && (addr_idx == `PCT_IDX_COUNT);
  wire rd_en = addr_rd && (addr_idx == `PCT_IDX_ENABLE);
  wire rd_flag = addr_rd && (addr_idx == `PCT_IDX_FLAGS);

  always_comb begin
    rdata_next = 32'h00000000;
    if (rd_ctl) begin
      rdata_next = {`PCT_ZERO_PAD_31, run_next};
    end else if (rd_cnt) begin
      rdata_next = {`PCT_ZERO_PAD_24, count_shown};
    end else if (rd_en) begin
      rdata_next = {`PCT_ZERO_PAD_28, en_next};
    end else if (rd_flag) begin
      rdata_next = {`PCT_ZERO_PAD_28, flag_next};
    end
  end

  // --------------------------------------------------------------------
  // Registers.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 30'h00000000;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_wr;
      wr_idx_reg <= addr_idx;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      run_reg <= 1'b0;
      en_reg <= `PCT_RST_IRQ;
      flag_reg <= `PCT_RST_IRQ;
    end else begin
      run_reg <= run_next;
      en_reg <= en_next;
      flag_reg <= flag_next;
    end
  end

  // --------------------------------------------------------------------
  // Counter core.
  // --------------------------------------------------------------------
  pct_counter #(
    .TICK_CYCLES(TICK_CYCLES)
  ) pct_counter_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(run_reg),
    .clear_in(count_clear),
    .count_out(count_value),
    .cause_out(cause)
  );

  // --------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------
  assign hrdata_out = rdata_reg;
  assign hreadyout_out = 1'b1 | unused_ok;
  assign hresp_out = `PCT_RESP_OKAY;
  assign irq_out = |(flag_reg & en_reg);
endmodule : pct_top

// ===== pkg/pct_consts.svh
// Constants of the periodic clock timer: offsets, fields, resets, timing.
// Functional notes
// - Counter advances only while count_run is 1; run is 0 after reset.
// - 8-bit read-only count from zero; writing 1 to count_clear zeroes it.
// - Four read-write enables, bits 3..0 for 32/8/2/1 Hz, reset zero.
// - Each cause sets its sticky flag; writing 1 clears, writing 0 keeps.
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define PCT_IDX_CONTROL 30'h00005000
`define PCT_IDX_COUNT 30'h00005001
`define PCT_IDX_ENABLE 30'h00005002
`define PCT_IDX_FLAGS 30'h00005003

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define PCT_BIT_RUN 0
`define PCT_BIT_CLEAR 4
`define PCT_IRQ_W 4
`define PCT_RST_BYTE 8'h00
`define PCT_RST_IRQ 4'h0
`define PCT_ZERO_PAD_24 24'h000000
`define PCT_ZERO_PAD_28 28'h0000000
`define PCT_ZERO_PAD_31 31'h00000000

// ----------------------------------------------------------------------
// Count bits whose falling edge marks each cause, 32/8/2/1 Hz.
// ----------------------------------------------------------------------
`define PCT_TAP_32HZ 2
`define PCT_TAP_8HZ 4
`define PCT_TAP_2HZ 6
`define PCT_TAP_1HZ 7

// ----------------------------------------------------------------------
// Timing: system clock and counter tick rate, in hertz.
// ----------------------------------------------------------------------
`define PCT_CLK_HZ 20000000
`define PCT_TICK_HZ 256
`define PCT_PRE_W 17
`define PCT_PRE_ZERO 17'h00000
`define PCT_PRE_ONE 17'h00001
`define PCT_HTRANS_NONSEQ_BIT 1
`define PCT_RESP_OKAY 1'h0

`endif

// ===== pkg/pct_pkg.sv
// Types shared by the periodic clock timer files.
package pct_pkg;
  typedef logic [7:0] pct_byte_t;
  typedef logic [3:0] pct_irq_t;
  typedef logic [16:0] pct_pre_t;
endpackage : pct_pkg

// ===== tb/pct_assertions.sv
// Concurrent checks on the periodic clock timer top-level ports.
`timescale 1ns/1ps
module pct_assertions (
  // Clock, reset and bus requests.
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  // Watched outputs.
  input wire logic [31:0] hrdata_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic take = hsel_in && hready_in && htrans_in[1];
  wire logic rd = take && !hwrite_in;
  a_pad_zero: assert property (hrdata_out[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_ctl_read: assert property (rd && haddr_in == 32'h00014000 |=>
    hrdata_out[7:1] == 7'h00) else $error("control read shows clear bit");
  a_en_read: assert property (rd && haddr_in == 32'h00014008 |=>
    hrdata_out[7:4] == 4'h0) else $error("enable reserved bits set");
  a_flag_read: assert property (rd && haddr_in == 32'h0001400c |=>
    hrdata_out[7:4] == 4'h0) else $error("flag reserved bits set");
  a_irq_drop: assert property (take && hwrite_in &&
    haddr_in == 32'h00014008 ##1 hwdata_in[3:0] == 4'h0 |=> !irq_out)
    else $error("interrupt stays up with all enables off");
  a_irq_reset: assert property ($rose(rst_b_in) |-> !irq_out)
    else $error("interrupt high after reset");
endmodule : pct_assertions

bind pct_top pct_assertions pct_assertions_i (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .irq_out(irq_out));

// ===== tb/periodic_clock_timer_test.sv
// Register-level test of the periodic clock timer over AHB-Lite.
`timescale 1ns/1ps
`include "pct_consts.svh"
module periodic_clock_timer_test;
  localparam logic [31:0] CTL = {`PCT_IDX_CONTROL, 2'b00};
  localparam logic [31:0] CNT = {`PCT_IDX_COUNT, 2'b00};
  localparam logic [31:0] EN = {`PCT_IDX_ENABLE, 2'b00};
  localparam logic [31:0] FLG = {`PCT_IDX_FLAGS, 2'b00};
  logic clk_in = 1'b0, rst_b_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic hready, irq;
  int failures = 0, checks = 0, cyc = 0;
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  // A short tick keeps a full count wrap near a thousand cycles.
  pct_top #(.TICK_CYCLES(4)) pct_top_i (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(), .irq_out(irq));
  initial forever #25 clk_in = ~clk_in;
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      close_out();
    end
  end
  task automatic xfer(input logic w, input logic [31:0] a, v);
    @(posedge clk_in);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= v;
    do @(posedge clk_in); while (hready !== 1'b1);
    d = hrdata;
    #1;
  endtask : xfer
  task automatic wr(input logic [31:0] a, v);
    xfer(1'b1, a, v);
  endtask : wr
  task automatic rchk(input string n, input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0);
    `CHK(n, e, d)
  endtask : rchk
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rchk("control", CTL, 32'h0);
    rchk("count", CNT, 32'h0);
    rchk("enable", EN, 32'h0);
    rchk("flags", FLG, 32'h0);
    `CHK("irq idle", 1'b0, irq)
    wr(32'h00014010, 32'hff);
    rchk("unmapped", 32'h00014010, 32'h0);
    rchk("unmapped ignored", EN, 32'h0);
    $display("test reset_values done");
    repeat (40) @(posedge clk_in);
    rchk("stopped count", CNT, 32'h0);
    wr(CTL, 32'h1);
    rchk("run bit", CTL, 32'h1);
    repeat (40) @(posedge clk_in);
    wr(CTL, 32'h0);
    xfer(1'b0, CNT, 32'h0);
    `CHK("advanced", 1'b1, d != 32'h0)
    repeat (30) @(posedge clk_in);
    rchk("held", CNT, d);
    wr(CTL, 32'h10);
    rchk("cleared", CNT, 32'h0);
    rchk("clear reads", CTL, 32'h0);
    $display("test run_clear done");
    wr(EN, 32'hff);
    rchk("enable bits", EN, 32'h0f);
    wr(EN, 32'h0);
    wr(CTL, 32'h1);
    repeat (1100) @(posedge clk_in);
    wr(CTL, 32'h0);
    rchk("all causes", FLG, 32'h0f);
    `CHK("masked irq", 1'b0, irq)
    for (int i = 0; i < 4; i++) begin
      wr(EN, 32'h1 << i);
      `CHK("enabled irq", 1'b1, irq)
    end
    wr(EN, 32'h1);
    wr(FLG, 32'h0e);
    rchk("partial clear", FLG, 32'h01);
    `CHK("irq kept", 1'b1, irq)
    wr(FLG, 32'h01);
    rchk("flag cleared", FLG, 32'h0);
    `CHK("irq dropped", 1'b0, irq)
    $display("test interrupts done");
    wr(EN, 32'h8);
    wr(CTL, 32'h1);
    repeat (40) @(posedge clk_in);
    `CHK("irq 32hz", 1'b1, irq)
    wr(EN, 32'h0);
    `CHK("irq masked off", 1'b0, irq)
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rchk("reset control", CTL, 32'h0);
    rchk("reset count", CNT, 32'h0);
    rchk("reset enable", EN, 32'h0);
    rchk("reset flags", FLG, 32'h0);
    `CHK("reset irq", 1'b0, irq)
    $display("test reset_mid_run done");
    close_out();
  end
endmodule : periodic_clock_timer_test
